// >>> logic/aop_playback.v
`timescale 1ns/1ps
`include "aop_defs.vh"
// Notes on behaviour
// R1: Every sample is a 16-bit code; all enabled channels change on one tick.
// R2: Three playback modes, chosen by software before start.
// R3: Single-pass: host loads the whole block before start.
// R4: Single-pass: emit each loaded frame once in order, then stop.
// R5: Streaming: host preloads, then keeps writing to avoid gaps.
// R6: Streaming: each frame emitted once in written order, never replayed.
// R7: Cyclic: host writes the full block before start.
// R8: Cyclic: replay block from first frame after last until stop.
// R9: Streaming underrun on tick: hold outputs, set sticky underrun flag.
module aop_playback (
    input wire sys_clk,
    input wire rst_n,
    input wire [`AOP_MODE_W-1:0] mode_sel,
    input wire [`AOP_CHANS-1:0] chan_en,
    input wire start,
    input wire stop,
    input wire update_tick,
    input wire wr_valid,
    output wire wr_ready,
    input wire [`AOP_CODE_W*`AOP_CHANS-1:0] wr_data,
    input wire underrun_clr,
    output reg [`AOP_CODE_W*`AOP_CHANS-1:0] dac_code_q,
    output reg dac_load_q,
    output wire running,
    output reg underrun_q,
    output reg done_q
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_LOAD = 3'b100;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [`AOP_MODE_W-1:0] mode_q;
    reg [`AOP_ADDR_W-1:0] wr_ptr_q;
    reg [`AOP_ADDR_W-1:0] rd_ptr_q;
    reg [`AOP_ADDR_W:0] count_q;
    reg [`AOP_ADDR_W:0] blk_len_q;
    wire [`AOP_CODE_W*`AOP_CHANS-1:0] mem_q;
    wire wr_fire;
    wire have_data;
    wire take;
    wire last_frame;
    wire [`AOP_ADDR_W-1:0] rd_next;
    wire starting;
    wire leaving;
    wire [`AOP_CODE_W*`AOP_CHANS-1:0] frame_now;
    reg wr_hit_q;
    reg [`AOP_CODE_W*`AOP_CHANS-1:0] byp_q;

    // Mode is latched at start only, so changing it mid-run has no effect
    function is_stream;
        input [`AOP_MODE_W-1:0] m;
        begin
            is_stream = (m == `AOP_MODE_STREAM);
        end
    endfunction

    // Only the three playback codes may start a run; code 3 is refused
    function mode_ok;
        input [`AOP_MODE_W-1:0] m;
        begin
            mode_ok = (m == `AOP_MODE_SINGLE) || (m == `AOP_MODE_STREAM)
                   || (m == `AOP_MODE_CYCLIC);
        end
    endfunction

    // Host may write when idle, or while streaming and not full
    assign wr_ready = (state_q == ST_IDLE) ? (count_q != `AOP_DEPTH)
                    : (is_stream(mode_q) && count_q != `AOP_DEPTH); // see R5
    assign wr_fire = wr_valid && wr_ready;
    assign running = (state_q != ST_IDLE);
    assign have_data = (count_q != 0);
    assign take = (state_q == ST_RUN) && update_tick && have_data;
    // In single and cyclic modes count_q holds frames left in the pass
    assign last_frame = (count_q == 1);
    assign rd_next = (mode_q == `AOP_MODE_CYCLIC && last_frame) ? {`AOP_ADDR_W{1'b0}}
                   : rd_ptr_q + 1'b1; // see R8

    aop_mem u_mem (
        .sys_clk(sys_clk),
        .wr_en(wr_fire),
        .wr_addr(wr_ptr_q),
        .wr_data(wr_data),
        .rd_addr(rd_ptr_q),
        .rd_data(mem_q)
    );

    // Run boundaries, used for capture and for emptying the store
    assign starting = (state_q == ST_IDLE) && (state_d == ST_LOAD);
    assign leaving = (state_q != ST_IDLE) && (state_d == ST_IDLE);
    // A frame written to the slot under the read pointer one cycle ago is not
    // yet in the registered read data, so it comes from the bypass copy
    assign frame_now = wr_hit_q ? byp_q : mem_q; // see R6

    // Sequencer next state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start && !stop && mode_ok(mode_sel) && (count_q != 0 || wr_fire)) begin
                    state_d = ST_LOAD; // see R2
                end
            end
            ST_LOAD: begin
                state_d = stop ? ST_IDLE : ST_RUN;
            end
            ST_RUN: begin
                if (stop) begin
                    state_d = ST_IDLE; // see R8
                end else if (take && last_frame && mode_q == `AOP_MODE_SINGLE) begin
                    state_d = ST_IDLE; // see R4
                end else if (take) begin
                    state_d = ST_LOAD; // wait one cycle for the next read word
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Sequencer state
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Mode and block length are captured on the start edge only
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= `AOP_MODE_SINGLE;
            blk_len_q <= {(`AOP_ADDR_W+1){1'b0}};
        end else if (starting) begin
            mode_q <= mode_sel; // see R2
            blk_len_q <= wr_fire ? count_q + 1'b1 : count_q;
        end
    end

    // Write pointer; leaving a run empties the store so a new block starts at zero
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= {`AOP_ADDR_W{1'b0}};
        end else if (leaving) begin
            wr_ptr_q <= {`AOP_ADDR_W{1'b0}};
        end else if (wr_fire) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    // Read pointer steps on each taken tick, wraps to zero in cyclic mode
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr_q <= {`AOP_ADDR_W{1'b0}};
        end else if (leaving) begin
            rd_ptr_q <= {`AOP_ADDR_W{1'b0}};
        end else if (take) begin
            rd_ptr_q <= rd_next; // see R6
        end
    end

    // Frame count: streaming counts unread frames, others frames left
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= {(`AOP_ADDR_W+1){1'b0}};
        end else if (leaving) begin
            count_q <= {(`AOP_ADDR_W+1){1'b0}};
        end else if (take && mode_q == `AOP_MODE_CYCLIC && last_frame) begin
            count_q <= blk_len_q; // see R8
        end else if (take && !wr_fire) begin
            count_q <= count_q - 1'b1; // see R6
        end else if (wr_fire && !take) begin
            count_q <= count_q + 1'b1;
        end
    end

    // Bypass: a write into an empty stream lands on the slot being read
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_hit_q <= 1'b0;
            byp_q <= {(`AOP_CODE_W*`AOP_CHANS){1'b0}};
        end else begin
            wr_hit_q <= wr_fire && (wr_ptr_q == rd_ptr_q); // see R6
            if (wr_fire) begin
                byp_q <= wr_data;
            end
        end
    end

    // Output codes: all enabled channels load together on one tick
    genvar g;
    generate
        for (g = 0; g < `AOP_CHANS; g = g + 1) begin : g_chan
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    dac_code_q[g*`AOP_CODE_W +: `AOP_CODE_W] <= `AOP_CODE_RST;
                end else if (take && chan_en[g]) begin
                    dac_code_q[g*`AOP_CODE_W +: `AOP_CODE_W] <=
                        frame_now[g*`AOP_CODE_W +: `AOP_CODE_W]; // see R1
                end
            end
        end
    endgenerate

    // Load strobe, done pulse and sticky underrun
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_load_q <= 1'b0;
            done_q <= 1'b0;
            underrun_q <= 1'b0;
        end else begin
            dac_load_q <= take; // see R1
            done_q <= (state_q != ST_IDLE) && (state_d == ST_IDLE);
            if (state_q == ST_RUN && update_tick && !have_data && is_stream(mode_q)) begin
                underrun_q <= 1'b1; // see R9
            end else if (underrun_clr) begin
                underrun_q <= 1'b0;
            end
        end
    end
endmodule // aop_playback

// >>> logic/aop_defs.vh
`ifndef AOP_DEFS_VH
`define AOP_DEFS_VH
`define AOP_CODE_W 16
`define AOP_CHANS 4
`define AOP_ADDR_W 8
`define AOP_DEPTH 256
`define AOP_MODE_W 2
`define AOP_MODE_SINGLE 2'h0
`define AOP_MODE_STREAM 2'h1
`define AOP_MODE_CYCLIC 2'h2
`define AOP_CODE_RST 16'h0000
`endif

// >>> logic/aop_mem.v
`timescale 1ns/1ps
`include "aop_defs.vh"
// Frame store: one word holds one code per channel, registered read
module aop_mem (
    input wire sys_clk,
    input wire wr_en,
    input wire [`AOP_ADDR_W-1:0] wr_addr,
    input wire [`AOP_CODE_W*`AOP_CHANS-1:0] wr_data,
    input wire [`AOP_ADDR_W-1:0] rd_addr,
    output reg [`AOP_CODE_W*`AOP_CHANS-1:0] rd_data
);
    reg [`AOP_CODE_W*`AOP_CHANS-1:0] mem [0:`AOP_DEPTH-1];

    // Write port and registered read port
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // aop_mem

// >>> dv/aop_playback_assertions.sv
`timescale 1ns/1ps
`include "aop_defs.vh"
// Port checks on update timing and status
module aop_playback_assertions (
    input wire sys_clk,
    input wire rst_n,
    input wire [`AOP_MODE_W-1:0] mode_sel,
    input wire update_tick,
    input wire underrun_clr,
    input wire wr_ready,
    input wire [`AOP_CODE_W*`AOP_CHANS-1:0] dac_code_q,
    input wire dac_load_q,
    input wire running,
    input wire underrun_q,
    input wire done_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    reg [`AOP_MODE_W-1:0] run_mode_q = `AOP_MODE_SINGLE;
    // Mode of the current run: follows the select while idle, held while running
    always @(posedge sys_clk) begin
        if (!running) begin
            run_mode_q <= mode_sel;
        end
    end
    sequence s_new;
        $changed(dac_code_q);
    endsequence
    // Any change of the output codes comes with the load strobe
    a_load_code: assert property (s_new |-> dac_load_q) else $error("no load");
    a_load_tick: assert property (dac_load_q |-> $past(update_tick)) else $error("bad load");
    a_done_idle: assert property (done_q |-> !running) else $error("done run");
    a_idle_hold: assert property (!running && $past(!running) |-> $stable(dac_code_q))
        else $error("idle change");
    a_under_set: assert property ($rose(underrun_q) |-> $stable(dac_code_q) && $past(update_tick))
        else $error("underrun");
    a_under_clr: assert property ($fell(underrun_q) |-> $past(underrun_clr))
        else $error("lost flag");
    a_run_wr: assert property (running && run_mode_q != `AOP_MODE_STREAM |-> !wr_ready)
        else $error("write open");
endmodule // aop_playback_assertions

// >>> dv/aop_host.sv
`timescale 1ns/1ps
`include "aop_defs.vh"
// Host writer: frame k holds base plus k on every channel
module aop_host (
    input wire sys_clk,
    input wire wr_ready,
    output reg wr_valid,
    output reg [`AOP_CODE_W*`AOP_CHANS-1:0] wr_data
);
    initial wr_valid = 0;
    initial wr_data = 0;
    reg hang = 0;
    // Offer at once, wait until ready is settled high, hold over the taking edge
    task put(input integer n, input [15:0] b);
        integer k, w;
        begin
            for (k = 0; k < n; k = k + 1) begin
                wr_data = {4{b + k[15:0]}};
                wr_valid = 1;
                for (w = 0; w < 50 && !wr_ready; w = w + 1) @(posedge sys_clk) #1;
                if (!wr_ready) hang = 1; // Bound used up, counted at the verdict
                @(posedge sys_clk) #1;
            end
            wr_valid = 0;
            wr_data = ~wr_data; // Released bus shows no stale frame
        end
    endtask
endmodule // aop_host

// >>> dv/analog_output_playback_test.sv
`timescale 1ns/1ps
`include "aop_defs.vh"
module analog_output_playback_test;
    reg sys_clk = 0, rst_n = 0, start = 0, stop = 0, tick = 0, uclr = 0;
    reg [1:0] mode_sel = 0;
    reg [3:0] chan_en = 4'hf;
    wire ready, valid, load, run, und, done;
    wire [63:0] data, code;
    integer errors = 0, cmp_count = 0, i;
    integer loads = 0, dones = 0;
    aop_host u_host (.sys_clk(sys_clk), .wr_ready(ready), .wr_valid(valid), .wr_data(data));
    aop_playback u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .mode_sel(mode_sel),
        .chan_en(chan_en), .start(start), .stop(stop), .update_tick(tick), .wr_valid(valid),
        .wr_ready(ready), .wr_data(data), .underrun_clr(uclr), .dac_code_q(code),
        .dac_load_q(load), .running(run), .underrun_q(und), .done_q(done));
    initial forever #5 sys_clk = ~sys_clk;
    // Tally one-cycle load and done pulses while they stand
    always @(posedge sys_clk) begin
        if (load) loads <= loads + 1;
        if (done) dones <= dones + 1;
    end
    // Compare and count
    task chk(input [39:0] n, input [63:0] e, input [63:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (e !== g) begin
                errors = errors + 1;
                $display("ERROR %0s exp %h got %h", n, e, g);
            end
        end
    endtask
    task cyc;
        @(posedge sys_clk) #1;
    endtask
    // Start pulse, then LOAD, then RUN
    task go(input [1:0] m);
        begin
            mode_sel = m;
            start = 1;
            cyc;
            start = 0;
            cyc;
        end
    endtask
    // Ticks two cycles apart
    task tk;
        begin
            tick = 1;
            cyc;
            tick = 0;
            cyc;
        end
    endtask
    task halt;
        begin
            stop = 1;
            cyc;
            stop = 0;
            cyc;
        end
    endtask
    task stop_test;
        begin
            if (u_host.hang)
                errors = errors + 1;
            $display("checks %0d errors %0d", cmp_count, errors);
            if (errors == 0 && cmp_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // Single pass of three frames, a spare tick changes nothing
    task t_single;
        begin
            u_host.put(3, 16'h0010);
            go(2'h3);
            chk("run", 0, run);
            go(`AOP_MODE_SINGLE);
            for (i = 0; i < 4; i = i + 1) begin
                tk;
                chk("code", {4{16'h0010 + (i < 3 ? i[15:0] : 16'h0002)}}, code);
            end
            chk("run", 0, run);
            chk("loads", 3, loads);
            chk("dones", 1, dones);
            $display("single done");
        end
    endtask
    // Cyclic replay wraps until stop, writes refused meanwhile
    task t_cyclic;
        begin
            u_host.put(2, 16'h0100);
            go(`AOP_MODE_CYCLIC);
            for (i = 0; i < 5; i = i + 1) begin
                tk;
                chk("code", {4{16'h0100 + i[0]}}, code);
            end
            chk("ready", 0, ready);
            halt;
            chk("run", 0, run);
            chk("loads", 8, loads);
            chk("dones", 2, dones);
            $display("cyclic done");
        end
    endtask
    // Streaming underrun holds codes, new frame follows, flag sticky
    task t_stream;
        begin
            u_host.put(1, 16'h0200);
            go(`AOP_MODE_STREAM);
            tk;
            chk("code", {4{16'h0200}}, code);
            tk;
            chk("code", {4{16'h0200}}, code);
            chk("under", 1, und);
            u_host.put(1, 16'h0201);
            chan_en = 4'h1;
            tk;
            chk("code", {{3{16'h0200}}, 16'h0201}, code);
            chan_en = 4'hf;
            chk("under", 1, und);
            uclr = 1;
            cyc;
            uclr = 0;
            chk("under", 0, und);
            halt;
            chk("loads", 10, loads);
            chk("dones", 3, dones);
            $display("stream done");
        end
    endtask
    initial begin
        repeat (4) cyc;
        rst_n = 1;
        t_single;
        t_cyclic;
        t_stream;
        stop_test;
    end
    initial begin
        #100000;
        errors = errors + 1;
        stop_test;
    end
endmodule // analog_output_playback_test
bind aop_playback aop_playback_assertions u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .mode_sel(mode_sel), .update_tick(update_tick), .underrun_clr(underrun_clr),
    .wr_ready(wr_ready), .dac_code_q(dac_code_q), .dac_load_q(dac_load_q),
    .running(running), .underrun_q(underrun_q), .done_q(done_q));
